//--- rtl/page_addr_gen.sv
// Registered byte address former: page pointer entry joined with page offset.
// Assumes the page list, index and offset are presented as next-cycle values.
module page_addr_gen #(
    parameter int PAGES = 5
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_b,
    input  wire logic [PAGES-1:0][31:0] i_page_list,
    input  wire logic [2:0]            i_cpage,
    input  wire logic [11:0]           i_offset,
    output logic      [31:0]           o_addr
);

    typedef struct packed {
        logic [31:0] addr;
    } addr_state_s;

    addr_state_s st;
    addr_state_s next_st;

    always_comb
    begin
        next_st = st;
        // Out-of-range index holds the last good address
        if (32'(i_cpage) < PAGES)
        begin
            next_st.addr = {i_page_list[i_cpage][31:12], i_offset};
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_addr = st.addr;

endmodule

//--- rtl/td_walker_pkg.sv
// Constants and state codes for the transfer descriptor buffer walker.
// Assumes byte-addressed 32-bit system memory and 32-byte-aligned descriptors.
package td_walker_pkg;

    // ************************************************
    // Memory layout
    // ************************************************
    localparam int              ADDR_W       = 32;
    localparam int              OFFSET_BITS  = 12;
    localparam int              DESC_ALIGN   = 5;
    localparam logic [11:0]     OFFSET_LAST  = 12'hFFF;
    localparam logic [11:0]     OFFSET_RST   = 12'h000;

    // ************************************************
    // Descriptor kinds and link pointer fields
    // ************************************************
    localparam logic            KIND_SITD    = 1'b0;
    localparam logic            KIND_QTD     = 1'b1;
    localparam int              LINK_T_BIT   = 0;
    localparam int              LINK_TYP_LSB = 1;
    localparam logic [1:0]      TYP_SITD     = 2'h2;

    // ************************************************
    // Split isochronous descriptor dword positions
    // ************************************************
    localparam logic [2:0]      SITD_LAST_IDX  = 3'h6;
    localparam logic [2:0]      SITD_RES_IDX   = 3'h3;
    localparam logic [2:0]      SITD_PTR_IDX   = 3'h4;
    localparam logic [2:0]      SITD_PAGES     = 3'h2;
    localparam int              SITD_BYTES_LSB = 16;
    localparam int              SITD_BYTES_W   = 10;

    // ************************************************
    // Queue transfer descriptor dword positions
    // ************************************************
    localparam logic [2:0]      QTD_LAST_IDX   = 3'h7;
    localparam logic [2:0]      QTD_RES_IDX    = 3'h2;
    localparam logic [2:0]      QTD_PTR_IDX    = 3'h3;
    localparam logic [2:0]      QTD_PAGES      = 3'h5;
    localparam int              QTD_BYTES_LSB  = 16;
    localparam int              QTD_BYTES_W    = 15;
    localparam int              QTD_CPAGE_LSB  = 12;
    localparam logic [14:0]     QTD_MAX_BYTES  = 15'h5000;

    // ************************************************
    // Status byte
    // ************************************************
    localparam int              ST_ACTIVE      = 7;
    localparam int              ST_HALTED      = 6;
    localparam int              ST_BUF_ERR     = 5;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_FETCH   = 3'b001,
        ST_CHECK   = 3'b010,
        ST_EXEC    = 3'b011,
        ST_WB_RES  = 3'b100,
        ST_WB_PAGE = 3'b101,
        ST_NEXT    = 3'b110
    } walk_state_e;

endpackage

//--- rtl/usb_host_td_buffer_walker.sv
// Descriptor fetch, page-list walk and result write-back for split iso and qTD.
// Assumes one memory master port with level request / one-cycle acknowledge,
// and a transaction engine on the same clock consuming one byte per pulse.
//
// Function
// - Full-speed iso traffic through the translator is run from split iso descriptors.
// - First dword of a split iso descriptor is the next link pointer.
// - Bytes 04-0B are static endpoint state; 0C-13 hold written-back results.
// - Next structure may be prefetched early, but executed only after completion.
// - Five pointers allow 20K with zero offset; 16K works at any alignment. The code sets buf_err on a byte at offset FFF of the last page.
// - Current-page index selects the pointer entry giving the start address.
// - Every physical page uses its own pointer, even when pages are adjacent.
// - Page crossing increments current-page index and takes the next pointer automatically.
// - Upper 20 pointer bits give the page; entry zero is the starting page for split iso.
module usb_host_td_buffer_walker (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST_B,
    input  wire logic        I_SCHED_START,
    input  wire logic        I_SCHED_KIND,
    input  wire logic [31:0] I_SCHED_LINK,
    output logic             O_MEM_RD_REQ,
    output logic             O_MEM_WR_REQ,
    output logic      [31:0] O_MEM_ADDR,
    output logic      [31:0] O_MEM_WR_DATA,
    input  wire logic        I_MEM_RD_ACK,
    input  wire logic [31:0] I_MEM_RD_DATA,
    input  wire logic        I_MEM_WR_ACK,
    output logic             O_XFER_START,
    output logic             O_XFER_KIND,
    output logic      [14:0] O_XFER_BYTES,
    output logic      [31:0] O_BUF_ADDR,
    output logic             O_BUF_ERR,
    input  wire logic        I_ENG_BYTE,
    input  wire logic        I_ENG_DONE,
    input  wire logic [7:0]  I_ENG_STATUS,
    output logic             O_CHAIN_DONE,
    output logic             O_BUSY
);

    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        td_walker_pkg::walk_state_e state;
        logic                       kind;
        logic [31:0]                desc_ptr;
        logic [2:0]                 idx;
        logic [7:0][31:0]           words;
        logic [2:0]                 cpage;
        logic [11:0]                offset;
        logic [14:0]                remain;
        logic                       buf_err;
        logic [7:0]                 status;
        logic                       pf_pending;
        logic                       pf_valid;
        logic [31:0]                pf_link;
        logic                       rd_req;
        logic                       wr_req;
        logic [31:0]                mem_addr;
        logic [31:0]                wr_data;
        logic                       xfer_start;
        logic [14:0]                xfer_bytes;
        logic                       chain_done;
        logic                       busy;
    } walker_state_s;

    walker_state_s         st;
    walker_state_s         next_st;
    logic [4:0][31:0]      next_pages;

    // ************************************************
    // Helpers
    // ************************************************
    function automatic logic [31:0] dword_addr(input logic [31:0] base, input logic [2:0] idx);
        dword_addr = base + {27'h0, idx, 2'b00};
    endfunction

    function automatic logic [31:0] link_base(input logic [31:0] link);
        link_base = {link[31:td_walker_pkg::DESC_ALIGN], {td_walker_pkg::DESC_ALIGN{1'b0}}};
    endfunction

    function automatic logic [2:0] page_count(input logic kind);
        page_count = (kind == td_walker_pkg::KIND_QTD) ? td_walker_pkg::QTD_PAGES : td_walker_pkg::SITD_PAGES;
    endfunction

    // ************************************************
    // Next-state logic
    // ************************************************
    always_comb
    begin
        next_st = st;
        next_st.xfer_start = 1'b0;
        next_st.chain_done = 1'b0;

        // Prefetch answer may land in any state but fetch
        if (st.rd_req && I_MEM_RD_ACK && st.state != td_walker_pkg::ST_FETCH)
        begin
            next_st.pf_link    = I_MEM_RD_DATA;
            next_st.pf_valid   = 1'b1;
            next_st.pf_pending = 1'b0;
            next_st.rd_req     = 1'b0;
        end

        unique case (st.state)
            td_walker_pkg::ST_IDLE:
            begin
                if (I_SCHED_START)
                begin
                    next_st.kind     = I_SCHED_KIND;
                    next_st.desc_ptr = link_base(I_SCHED_LINK);
                    next_st.pf_valid = 1'b0;
                    if (I_SCHED_LINK[td_walker_pkg::LINK_T_BIT])
                    begin
                        next_st.chain_done = 1'b1;
                    end
                    else
                    begin
                        next_st.idx      = 3'h0;
                        next_st.rd_req   = 1'b1;
                        next_st.mem_addr = link_base(I_SCHED_LINK);
                        next_st.state    = td_walker_pkg::ST_FETCH;
                    end
                end
            end
            td_walker_pkg::ST_FETCH:
            begin
                if (I_MEM_RD_ACK)
                begin
                    next_st.words[st.idx] = I_MEM_RD_DATA;
                    if (st.idx == ((st.kind == td_walker_pkg::KIND_QTD) ? td_walker_pkg::QTD_LAST_IDX
                                                                          : td_walker_pkg::SITD_LAST_IDX))
                    begin
                        next_st.rd_req = 1'b0;
                        next_st.state  = td_walker_pkg::ST_CHECK;
                    end
                    else
                    begin
                        next_st.idx      = st.idx + 3'h1;
                        next_st.mem_addr = dword_addr(st.desc_ptr, st.idx + 3'h1);
                    end
                end
            end
            td_walker_pkg::ST_CHECK:
            begin
                next_st.buf_err = 1'b0;
                if (st.kind == td_walker_pkg::KIND_QTD)
                begin
                    next_st.remain = st.words[td_walker_pkg::QTD_RES_IDX]
                                     [td_walker_pkg::QTD_BYTES_LSB +: td_walker_pkg::QTD_BYTES_W];
                    next_st.cpage  = st.words[td_walker_pkg::QTD_RES_IDX][td_walker_pkg::QTD_CPAGE_LSB +: 3];
                    next_st.offset = st.words[td_walker_pkg::QTD_PTR_IDX][11:0];
                    next_st.status = st.words[td_walker_pkg::QTD_RES_IDX][7:0];
                end
                else
                begin
                    next_st.remain = {5'h00, st.words[td_walker_pkg::SITD_RES_IDX]
                                     [td_walker_pkg::SITD_BYTES_LSB +: td_walker_pkg::SITD_BYTES_W]};
                    next_st.cpage  = 3'h0;
                    next_st.offset = st.words[td_walker_pkg::SITD_PTR_IDX][11:0];
                    next_st.status = st.words[td_walker_pkg::SITD_RES_IDX][7:0];
                end
                if (!next_st.status[td_walker_pkg::ST_ACTIVE])
                begin
                    next_st.state = td_walker_pkg::ST_NEXT;
                end
                else if (next_st.remain > td_walker_pkg::QTD_MAX_BYTES ||
                         next_st.cpage >= page_count(st.kind))
                begin
                    // Refused: results written back halted, nothing executed
                    next_st.buf_err = 1'b1;
                    next_st.state   = td_walker_pkg::ST_WB_RES;
                end
                else
                begin
                    next_st.xfer_start = 1'b1;
                    next_st.xfer_bytes = next_st.remain;
                    next_st.pf_pending = !st.words[0][td_walker_pkg::LINK_T_BIT];
                    next_st.state      = td_walker_pkg::ST_EXEC;
                end
            end
            td_walker_pkg::ST_EXEC:
            begin
                // Early read of the next structure's link dword only
                if (st.pf_pending && !st.rd_req && !st.pf_valid)
                begin
                    next_st.rd_req   = 1'b1;
                    next_st.mem_addr = link_base(st.words[0]);
                end
                if (I_ENG_BYTE)
                begin
                    if (st.remain == 15'h0000)
                    begin
                        next_st.buf_err = 1'b1;
                    end
                    else
                    begin
                        next_st.remain = st.remain - 15'h0001;
                    end
                    if (st.offset == td_walker_pkg::OFFSET_LAST)
                    begin
                        next_st.offset = td_walker_pkg::OFFSET_RST;
                        if (st.cpage + 3'h1 >= page_count(st.kind))
                        begin
                            next_st.buf_err = 1'b1;
                        end
                        else
                        begin
                            next_st.cpage = st.cpage + 3'h1;
                        end
                    end
                    else
                    begin
                        next_st.offset = st.offset + 12'h001;
                    end
                end
                if (I_ENG_DONE)
                begin
                    next_st.status = I_ENG_STATUS;
                    next_st.state  = td_walker_pkg::ST_WB_RES;
                end
            end
            td_walker_pkg::ST_WB_RES:
            begin
                if (!st.wr_req && !st.rd_req)
                begin
                    next_st.wr_req   = 1'b1;
                    next_st.status[td_walker_pkg::ST_ACTIVE] = 1'b0;
                    next_st.status[td_walker_pkg::ST_HALTED] = st.status[td_walker_pkg::ST_HALTED] | st.buf_err;
                    next_st.status[td_walker_pkg::ST_BUF_ERR] = st.status[td_walker_pkg::ST_BUF_ERR] | st.buf_err;
                    if (st.kind == td_walker_pkg::KIND_QTD)
                    begin
                        next_st.mem_addr = dword_addr(st.desc_ptr, td_walker_pkg::QTD_RES_IDX);
                        next_st.wr_data  = {st.words[td_walker_pkg::QTD_RES_IDX][31], st.remain,
                                            st.words[td_walker_pkg::QTD_RES_IDX][15], st.cpage,
                                            st.words[td_walker_pkg::QTD_RES_IDX][11:8], next_st.status};
                    end
                    else
                    begin
                        next_st.mem_addr = dword_addr(st.desc_ptr, td_walker_pkg::SITD_RES_IDX);
                        next_st.wr_data  = {st.words[td_walker_pkg::SITD_RES_IDX][31:26], st.remain[9:0],
                                            st.words[td_walker_pkg::SITD_RES_IDX][15:8], next_st.status};
                    end
                end
                else if (st.wr_req && I_MEM_WR_ACK)
                begin
                    next_st.wr_req = 1'b0;
                    next_st.state  = td_walker_pkg::ST_WB_PAGE;
                end
            end
            td_walker_pkg::ST_WB_PAGE:
            begin
                if (!st.wr_req)
                begin
                    next_st.wr_req   = 1'b1;
                    next_st.mem_addr = dword_addr(st.desc_ptr, (st.kind == td_walker_pkg::KIND_QTD)
                                                  ? td_walker_pkg::QTD_PTR_IDX : td_walker_pkg::SITD_PTR_IDX);
                    next_st.wr_data  = {st.words[(st.kind == td_walker_pkg::KIND_QTD) ? td_walker_pkg::QTD_PTR_IDX
                                        : td_walker_pkg::SITD_PTR_IDX][31:12], st.offset};
                end
                else if (I_MEM_WR_ACK)
                begin
                    next_st.wr_req = 1'b0;
                    next_st.state  = td_walker_pkg::ST_NEXT;
                end
            end
            td_walker_pkg::ST_NEXT:
            begin
                next_st.pf_valid   = 1'b0;
                next_st.pf_pending = 1'b0;
                if (st.words[0][td_walker_pkg::LINK_T_BIT] || (st.kind == td_walker_pkg::KIND_SITD &&
                    st.words[0][td_walker_pkg::LINK_TYP_LSB +: 2] != td_walker_pkg::TYP_SITD))
                begin
                    next_st.chain_done = 1'b1;
                    next_st.state      = td_walker_pkg::ST_IDLE;
                end
                else
                begin
                    next_st.desc_ptr = link_base(st.words[0]);
                    next_st.rd_req   = 1'b1;
                    next_st.state    = td_walker_pkg::ST_FETCH;
                    // Reuse the prefetched link dword, skip its re-read
                    if (st.pf_valid)
                    begin
                        next_st.words[0] = st.pf_link;
                        next_st.idx      = 3'h1;
                        next_st.mem_addr = dword_addr(link_base(st.words[0]), 3'h1);
                    end
                    else
                    begin
                        next_st.idx      = 3'h0;
                        next_st.mem_addr = link_base(st.words[0]);
                    end
                end
            end
            default:
            begin
                next_st.state = td_walker_pkg::ST_IDLE;
            end
        endcase

        next_st.busy = (next_st.state != td_walker_pkg::ST_IDLE);
    end

    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ************************************************
    // Page list in entry order for the address former
    // ************************************************
    always_comb
    begin
        if (next_st.kind == td_walker_pkg::KIND_QTD)
        begin
            next_pages = next_st.words[7:3];
        end
        else
        begin
            next_pages = {96'h0, next_st.words[5], next_st.words[4]};
        end
    end

    page_addr_gen #(
        .PAGES (5)
    ) u_page_addr (
        .i_clk       (I_CORE_CLK),
        .i_rst_b     (I_RST_B),
        .i_page_list (next_pages),
        .i_cpage     (next_st.cpage),
        .i_offset    (next_st.offset),
        .o_addr      (O_BUF_ADDR)
    );

    assign O_MEM_RD_REQ  = st.rd_req;
    assign O_MEM_WR_REQ  = st.wr_req;
    assign O_MEM_ADDR    = st.mem_addr;
    assign O_MEM_WR_DATA = st.wr_data;
    assign O_XFER_START  = st.xfer_start;
    assign O_XFER_KIND   = st.kind;
    assign O_XFER_BYTES  = st.xfer_bytes;
    assign O_BUF_ERR     = st.buf_err;
    assign O_CHAIN_DONE  = st.chain_done;
    assign O_BUSY        = st.busy;

endmodule

//--- tb/td_mem_model.sv
// Behavioural system memory: descriptors in, write-backs out.
// Assumes word index from address bits [7:2]; all descriptors below 0x100.
module td_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_slow,
    input  wire logic        i_rd_req,
    input  wire logic        i_wr_req,
    input  wire logic [31:0] i_addr,
    input  wire logic [31:0] i_wr_data,
    output logic             o_rd_ack,
    output logic             o_wr_ack,
    output logic      [31:0] o_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] m [0:63];
    logic [1:0]  wait_cnt;
    initial
    begin
        foreach (m[i]) m[i] = 32'h0;
        o_rd_ack = 1'b0;
        o_wr_ack = 1'b0;
        o_rd_data = 32'h0;
        wait_cnt = 2'h0;
    end
    always @(posedge i_clk)
    begin
        o_rd_ack <= 1'b0;
        o_wr_ack <= 1'b0;
        // Data toggles when not valid, so a stale sample never looks right
        o_rd_data <= ~o_rd_data;
        if (!i_rst_b)
            wait_cnt <= 2'h0;
        else if ((i_rd_req || i_wr_req) && !o_rd_ack && !o_wr_ack)
        begin
            if (i_slow && wait_cnt != 2'h2)
                wait_cnt <= wait_cnt + 2'h1;
            else
            begin
                wait_cnt <= 2'h0;
                o_rd_ack <= i_rd_req;
                o_wr_ack <= i_wr_req;
                if (i_rd_req) o_rd_data <= m[i_addr[7:2]];
                if (i_wr_req) m[i_addr[7:2]] <= i_wr_data;
            end
        end
    end
endmodule

//--- tb/td_walker_monitor.sv
// Port-level assertions for the descriptor walker.
// Assumes one clock domain and a synchronous active-low reset.
module td_walker_monitor (
    input wire logic        I_CORE_CLK,
    input wire logic        I_RST_B,
    input wire logic        O_MEM_RD_REQ,
    input wire logic        O_MEM_WR_REQ,
    input wire logic [31:0] O_MEM_ADDR,
    input wire logic [31:0] O_MEM_WR_DATA,
    input wire logic        I_MEM_RD_ACK,
    input wire logic        I_MEM_WR_ACK,
    input wire logic        O_XFER_START,
    input wire logic [31:0] O_BUF_ADDR,
    input wire logic        I_ENG_BYTE,
    input wire logic        I_ENG_DONE
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************
    // Transaction tracking and checks
    // ************************************************
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_B);
    logic in_exec;
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B) in_exec <= 1'b0;
        else if (O_XFER_START) in_exec <= 1'b1;
        else if (I_ENG_DONE) in_exec <= 1'b0;
    end
    rd_hold_a:
        assert property (O_MEM_RD_REQ && !I_MEM_RD_ACK |=> O_MEM_RD_REQ && $stable(O_MEM_ADDR))
        else $error("read request not held");
    wr_hold_a:
        assert property (O_MEM_WR_REQ && !I_MEM_WR_ACK |=> O_MEM_WR_REQ && $stable({O_MEM_ADDR, O_MEM_WR_DATA}))
        else $error("write request not held");
    rd_advance_a:
        assert property (O_MEM_RD_REQ && I_MEM_RD_ACK |=> !O_MEM_RD_REQ || O_MEM_ADDR == $past(O_MEM_ADDR) + 32'h4)
        else $error("fetch address not ascending");
    no_overlap_a:
        assert property (in_exec |-> !O_XFER_START && !O_MEM_WR_REQ)
        else $error("new work before transaction end");
    done_wb_a:
        assert property (in_exec && I_ENG_DONE |-> ##[1:8] O_MEM_WR_REQ)
        else $error("no write-back after done");
    page_wrap_a:
        assert property (in_exec && I_ENG_BYTE && !I_ENG_DONE && O_BUF_ADDR[11:0] == 12'hFFF
                         |=> O_BUF_ADDR[11:0] == 12'h000)
        else $error("offset did not wrap");
    byte_step_a:
        assert property (in_exec && I_ENG_BYTE && !I_ENG_DONE && O_BUF_ADDR[11:0] != 12'hFFF
                         |=> O_BUF_ADDR == $past(O_BUF_ADDR) + 32'h1)
        else $error("buffer address not stepped");
    addr_hold_a:
        assert property (in_exec && !I_ENG_BYTE && !I_ENG_DONE |=> $stable(O_BUF_ADDR))
        else $error("buffer address moved idle");
endmodule
bind usb_host_td_buffer_walker td_walker_monitor u_mon (.I_CORE_CLK, .I_RST_B, .O_MEM_RD_REQ, .O_MEM_WR_REQ,
    .O_MEM_ADDR, .O_MEM_WR_DATA, .I_MEM_RD_ACK, .I_MEM_WR_ACK, .O_XFER_START, .O_BUF_ADDR, .I_ENG_BYTE, .I_ENG_DONE);

//--- tb/testbench.sv
// Self-checking bench: qTD page walk, split iso chain, size limits.
// Assumes the memory model as far side; the bench plays the engine.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        start = 1'b0;
    logic        kind = 1'b0;
    logic        slow = 1'b0;
    logic        eb = 1'b0;
    logic        ed = 1'b0;
    logic [31:0] link = 32'h0;
    logic [7:0]  est = 8'h03;
    logic        rd_req, wr_req, rd_ack, wr_ack, xs, xk, be, cd, busy;
    logic [31:0] addr, wd, rd, ba;
    logic [14:0] xb;
    int          error_cnt = 0;
    int          compares = 0;
    int          cyc = 0;
    usb_host_td_buffer_walker u_dut (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_SCHED_START(start),
        .I_SCHED_KIND(kind), .I_SCHED_LINK(link), .O_MEM_RD_REQ(rd_req), .O_MEM_WR_REQ(wr_req),
        .O_MEM_ADDR(addr), .O_MEM_WR_DATA(wd), .I_MEM_RD_ACK(rd_ack), .I_MEM_RD_DATA(rd),
        .I_MEM_WR_ACK(wr_ack), .O_XFER_START(xs), .O_XFER_KIND(xk), .O_XFER_BYTES(xb), .O_BUF_ADDR(ba),
        .O_BUF_ERR(be), .I_ENG_BYTE(eb), .I_ENG_DONE(ed), .I_ENG_STATUS(est), .O_CHAIN_DONE(cd), .O_BUSY(busy));
    td_mem_model u_mem (.i_clk(clk), .i_rst_b(rst_b), .i_slow(slow), .i_rd_req(rd_req), .i_wr_req(wr_req),
        .i_addr(addr), .i_wr_data(wd), .o_rd_ack(rd_ack), .o_wr_ack(wr_ack), .o_rd_data(rd));
    initial forever #12.5 clk = ~clk;
    // ************************************************
    // Shared tasks
    // ************************************************
    task automatic tick;
        @(posedge clk);
        #2;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wait_hi(input logic sel_done, input string n);
        for (int k = 0; k < 300 && (sel_done ? cd : xs) !== 1'b1; k++) tick();
        chk(n, 32'h1, 32'(sel_done ? cd : xs));
    endtask
    // Engine byte one cycle after the previous edge; done rides the last byte
    task automatic byte_step(input logic last);
        tick();
        eb = 1'b1;
        ed = last;
        tick();
        eb = 1'b0;
        ed = 1'b0;
    endtask
    task automatic run(input logic k, input logic [31:0] l);
        repeat (3) tick();
        start = 1'b1;
        kind = k;
        link = l;
        tick();
        start = 1'b0;
    endtask
    task automatic complete_run;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ************************************************
    // Scenarios
    // ************************************************
    task automatic s_qtd;
        u_mem.m[8] = 32'h1;
        u_mem.m[10] = 32'h0003_1080;
        u_mem.m[11] = 32'h0000_0FFE;
        u_mem.m[12] = 32'h0000_1000;
        u_mem.m[13] = 32'h0000_7000;
        run(1'b1, 32'h20);
        wait_hi(1'b0, "q_start");
        chk("q_kind", 32'h1, 32'(xk));
        chk("q_bytes", 32'h3, 32'(xb));
        chk("q_addr0", 32'h1FFE, ba);
        byte_step(1'b0);
        chk("q_addr1", 32'h1FFF, ba);
        byte_step(1'b0);
        chk("q_addr2", 32'h7000, ba);
        byte_step(1'b1);
        wait_hi(1'b1, "q_done");
        chk("q_status", 32'h3, 32'(u_mem.m[10][7:0]));
        chk("q_cpage", 32'h2, 32'(u_mem.m[10][14:12]));
        chk("q_remain", 32'h0, 32'(u_mem.m[10][30:16]));
        chk("q_offset", 32'h1, 32'(u_mem.m[11][11:0]));
    endtask
    task automatic s_sitd;
        int n = 0;
        u_mem.m[16] = 32'h64;
        u_mem.m[17] = 32'hA5A5_1234;
        u_mem.m[19] = 32'h0002_0080;
        u_mem.m[20] = 32'h0000_3FFF;
        u_mem.m[21] = 32'h0000_9000;
        u_mem.m[24] = 32'h1;
        run(1'b0, 32'h40);
        wait_hi(1'b0, "s_start");
        chk("s_kind", 32'h0, 32'(xk));
        chk("s_bytes", 32'h2, 32'(xb));
        chk("s_addr0", 32'h3FFF, ba);
        byte_step(1'b0);
        chk("s_addr1", 32'h9000, ba);
        repeat (10)
        begin
            tick();
            n += int'(xs);
        end
        chk("s_early", 32'h0, 32'(n));
        byte_step(1'b1);
        wait_hi(1'b1, "s_done");
        chk("s_status", 32'h3, 32'(u_mem.m[19][7:0]));
        chk("s_remain", 32'h0, 32'(u_mem.m[19][25:16]));
        chk("s_offset", 32'h1, 32'(u_mem.m[20][11:0]));
        chk("s_static", 32'hA5A5_1234, u_mem.m[17]);
        chk("s_skip", 32'h0, u_mem.m[27]);
    endtask
    task automatic s_limit;
        int n = 0;
        u_mem.m[32] = 32'h1;
        u_mem.m[34] = 32'h5000_0080;
        u_mem.m[35] = 32'h0000_A000;
        run(1'b1, 32'h80);
        wait_hi(1'b0, "l_start");
        chk("l_bytes", 32'h5000, 32'(xb));
        byte_step(1'b1);
        wait_hi(1'b1, "l_done");
        u_mem.m[34] = 32'h5001_0080;
        run(1'b1, 32'h80);
        for (int k = 0; k < 300 && cd !== 1'b1; k++)
        begin
            tick();
            n += int'(xs);
        end
        chk("l_refuse", 32'h0, 32'(n));
        chk("l_err", 32'h1, 32'(be));
        chk("l_status", 32'h60, 32'(u_mem.m[34][7:0]));
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    initial
    begin
        repeat (6) tick();
        rst_b = 1'b1;
        chk("busy_rst", 32'h0, 32'(busy));
        s_qtd();
        slow = 1'b1;
        s_sitd();
        s_limit();
        complete_run();
    end
endmodule
